// ### tb/rsc_far_model.sv
/*
 * far side of the reset controller: rc oscillator and reset pin.
 * assumes the bench drives pin_low to press the reset pin.
 */
`timescale 1ns/1ns

module rsc_far_model
(
  input wire logic pin_low,
  output logic wdt_osc,
  output logic ext_rst_n
);
  // **********
  // rc clock and pin
  // **********

  // free running, unrelated to clk_sys, also in sleep
  initial
  begin
    wdt_osc = 1'b0;
    forever #37 wdt_osc = ~wdt_osc;
  end

  // pull-up holds the pin high when released
  assign ext_rst_n = ~pin_low;
endmodule

// ### tb/tb_top.sv
/*
 * bench of the reset controller: supply, pins, sleep, bus traffic.
 * assumes rsc_far_model supplies the rc clock and pin pull-up.
 */
`timescale 1ns/1ns

module tb_top;
  // **********
  // signals
  // **********
  logic clk_sys;
  logic arst_n = 1'b0;
  logic por_ok = 1'b0;
  logic bod_low = 1'b0;
  logic pin_low = 1'b0;
  logic debug_pin_n = 1'b1;
  logic wdt_timeout = 1'b0;
  logic sleep_req = 1'b0;
  logic wdt_osc, ext_rst_n, osc_d;
  logic [7:0] gpio_in, mask;
  logic [31:0] d;
  logic [1:0] r;
  int fail_count, tests_run, cycles, osc_n;
  rsc_pkg::rsc_axi_req_t req = '0;
  rsc_pkg::rsc_axi_rsp_t rsp;
  rsc_pkg::rsc_ctl_t ctl;

  rsc_far_model rsc_far_model_inst (.pin_low(pin_low),
    .wdt_osc(wdt_osc), .ext_rst_n(ext_rst_n));

  rsc_reset_ctrl rsc_reset_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .ce(1'b1), .wdt_osc(wdt_osc), .por_ok(por_ok), .bod_low(bod_low),
    .ext_rst_n(ext_rst_n), .debug_pin_n(debug_pin_n),
    .wdt_timeout(wdt_timeout), .gpio_in(gpio_in), .sleep_req(sleep_req),
    .axi_req(req), .axi_rsp(rsp), .ctl(ctl));

  // clock generator
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // rc edges counted while a reset waits on its oscillator phase;
  // cleared whenever the core runs so no earlier reset leaks in
  always @(posedge clk_sys)
  begin
    osc_d <= wdt_osc;
    if (ctl.core_rst !== 1'b1)
      osc_n <= 0;
    else if (wdt_osc && !osc_d && !ctl.sysclk_en && por_ok && !bod_low)
      osc_n <= osc_n + 1;
  end

  // hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // **********
  // tasks
  // **********
  task automatic end_of_test;
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // write: both channels offered, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req.awaddr <= a;
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    chk(rsp.bresp, 2'h0);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] rs);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (rsp.arready === 1'b1)
        req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic wdog;
    wdt_timeout <= 1'b1;
    cyc(4);
    wdt_timeout <= 1'b0;
  endtask

  // enter sleep and check the stopped clocks
  task automatic nap;
    sleep_req <= 1'b1;
    cyc(1);
    sleep_req <= 1'b0;
    cyc(3);
    @(negedge clk_sys);
    chk({ctl.xtal_en, ctl.sysclk_en, ctl.bod_en, ctl.periph_idle,
      ctl.pin_capture_en}, 5'b00010);
    cyc(1);
  endtask

  // follow one reset sequence to its exit
  task automatic seq(input int n, input logic [3:0] fl,
    input logic [1:0] rk, input logic irq);
    int t;
    int a;
    int s;
    t = 0;
    s = 0;
    while (ctl.core_rst !== 1'b1 && t < 99)
    begin
      @(negedge clk_sys);
      t++;
    end
    chk({ctl.ctrl_rst, ctl.ocd_rst}, rk);
    while (ctl.sysclk_en !== 1'b1 && t < 9999)
    begin
      @(negedge clk_sys);
      t++;
    end
    a = osc_n;
    chk(a >= n - 1 && a <= n + 1, 1'b1);
    while (ctl.core_rst === 1'b1 && s < 999)
    begin
      @(negedge clk_sys);
      s++;
    end
    chk(s, 16);
    chk({ctl.vec_fetch, ctl.wdt_irq, ctl.vec_addr},
      {1'b1, irq, 16'h0002});
    cyc(1);
    rd(8'h00, d, r);
    chk(d, fl);
  endtask

  // **********
  // main sequence
  // **********
  initial
  begin
    void'($urandom(32'h027bdc98));
    gpio_in = 8'($urandom);
    cyc(12);
    arst_n <= 1'b1;
    cyc(3);
    por_ok <= 1'b1;
    seq(514, 4'h8, 2'b11, 1'b0);
    pin_low <= 1'b1;
    cyc(3 + $urandom % 20);
    pin_low <= 1'b0;
    seq(66, 4'h4, 2'b11, 1'b0);
    pin_low <= 1'b1;
    cyc(1200);
    @(negedge clk_sys);
    chk(ctl.core_rst, 1'b1);
    cyc(1);
    pin_low <= 1'b0;
    cyc(5);
    @(negedge clk_sys);
    chk(ctl.core_rst, 1'b0);
    cyc(1);
    wdog();
    seq(66, 4'h2, 2'b11, 1'b0);
    wr(8'h08, 8'h02);
    wdog();
    cyc(20);
    @(negedge clk_sys);
    chk(ctl.core_rst, 1'b0);
    cyc(1);
    mask = 8'h01 << ($urandom % 8);
    wr(8'h0c, mask);
    nap();
    gpio_in <= gpio_in ^ ~mask;
    bod_low <= 1'b1;
    cyc(20);
    bod_low <= 1'b0;
    rd(8'h10, d, r);
    chk(d, 4);
    gpio_in <= gpio_in ^ mask;
    seq(514, 4'h1, 2'b00, 1'b0);
    nap();
    wdog();
    seq(514, 4'h3, 2'b00, 1'b1);
    nap();
    debug_pin_n <= 1'b0;
    cyc(4);
    debug_pin_n <= 1'b1;
    seq(514, 4'h0, 2'b11, 1'b0);
    wr(8'h04, 8'h02);
    seq(514, 4'h0, 2'b10, 1'b0);
    cyc(1);
    rd(8'h14, d, r);
    chk(r, 2'h2);
    pin_low <= 1'b1;
    bod_low <= 1'b1;
    cyc(30);
    pin_low <= 1'b0;
    rd(8'h10, d, r);
    chk(d, 0);
    bod_low <= 1'b0;
    cyc(4);
    seq(514, 4'h8, 2'b11, 1'b0);
    end_of_test();
  end
endmodule

// ### verilog/rsc_defs.svh
/*
 * constants of the reset and sleep-recovery controller: register offsets,
 * field positions, reset values and sequence counts.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ***************************************************************
// register byte addresses
// ***************************************************************
`define RSC_ADDR_W 8
`define RSC_OFS_WDCTL 8'h00
`define RSC_OFS_DBGCTL 8'h04
`define RSC_OFS_OPTION 8'h08
`define RSC_OFS_WAKE_EN 8'h0c
`define RSC_OFS_STATUS 8'h10

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define RSC_FLAG_W 4
`define RSC_FLAG_SLEEP 0
`define RSC_FLAG_WDT 1
`define RSC_FLAG_EXT 2
`define RSC_FLAG_POR 3
`define RSC_DBG_RST_BIT 1
`define RSC_OPT_WDT_RST 0
`define RSC_OPT_IRQ_EN 1
`define RSC_OPT_RST 2'h1
`define RSC_GPIO_W 8
`define RSC_VEC_ADDR 16'h0002

// ***************************************************************
// synchronised input bus layout
// ***************************************************************
`define RSC_SYN_W 14
`define RSC_SYN_OSC 0
`define RSC_SYN_POR 1
`define RSC_SYN_BOD 2
`define RSC_SYN_EXT 3
`define RSC_SYN_DBG 4
`define RSC_SYN_WDT 5
`define RSC_SYN_GPIO 6
`define RSC_SYN_RST 14'h0018

// ***************************************************************
// sequence counts
// ***************************************************************
`define RSC_OSC_CNT_W 10
`define RSC_OSC_LONG 10'h202
`define RSC_OSC_SHORT 10'h042
`define RSC_SYS_CNT_W 5
`define RSC_SYS_LAST 5'h0f

// ***************************************************************
// bus answers
// ***************************************************************
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

`endif

// ### verilog/rsc_pkg.sv
/*
 * types of the reset and sleep-recovery controller: states, reset kinds,
 * bus carriers and the controller's state record.
 * assumes rsc_defs.svh on the include path.
 */
`include "rsc_defs.svh"

package rsc_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_OSC,
    ST_SYSCLK,
    ST_RUN,
    ST_SLEEP
  } rsc_state_t;

  // kind of reset sequence under way
  typedef enum logic [1:0] {
    K_SYSTEM,
    K_SHORT,
    K_RECOV
  } rsc_kind_t;

  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [`RSC_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`RSC_ADDR_W-1:0] araddr;
    logic rready;
  } rsc_axi_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsc_axi_rsp_t;

  // reset and clock controls toward the core
  typedef struct packed {
    logic core_rst;
    logic ctrl_rst;
    logic ocd_rst;
    logic xtal_en;
    logic sysclk_en;
    logic periph_idle;
    logic bod_en;
    logic pin_capture_en;
    logic vec_fetch;
    logic [15:0] vec_addr;
    logic wdt_irq;
  } rsc_ctl_t;

  // whole state of the controller
  typedef struct packed {
    rsc_state_t st;
    rsc_kind_t kind;
    logic [`RSC_OSC_CNT_W-1:0] osc_cnt;
    logic [`RSC_SYS_CNT_W-1:0] sys_cnt;
    logic osc_prev;
    logic wdt_prev;
    logic [`RSC_GPIO_W-1:0] gpio_prev;
    logic [`RSC_FLAG_W-1:0] pend;
    logic irq_pend;
    logic keep_ocd;
    logic [`RSC_FLAG_W-1:0] flags;
    logic dbg_req;
    logic [1:0] option;
    logic [`RSC_GPIO_W-1:0] wake_en;
    logic aw_got;
    logic w_got;
    logic [`RSC_ADDR_W-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane0;
    rsc_axi_rsp_t rsp;
    rsc_ctl_t ctl;
  } rsc_regs_t;

  // state of the input synchroniser
  typedef struct packed {
    logic [`RSC_SYN_W-1:0] s1;
    logic [`RSC_SYN_W-1:0] s2;
  } rsc_sync_t;

endpackage

// ### verilog/rsc_reset_ctrl.sv
/*
 * reset and sleep-recovery controller: arbitrates reset sources, counts
 * the oscillator and system clock delays, keeps cause flags, and exposes
 * its registers over axi4-lite.
 * assumes supply monitors, reset pin, debug pin, watchdog and wake pins
 * arrive asynchronous; sleep_req comes from the cpu on clk_sys.
 */
// The implementer's own choices: the address map and register access over AXI4-Lite.
// Functional notes
// - supply faults outrank every other reset source
// - power-up: 514 osc edges then 16 clocks
// - on exit cpu fetches vector at 0002h/0003h
// - power-on or brownout reset sets power flag
// - brownout holds reset until supply recovers
// - brownout detector disabled during sleep
// - watchdog resets only when select option set
// - watchdog reset sets watchdog cause flag
// - reset pin low starts short reset
// - pin low holds reset; release ends it
// - pin short reset sets external cause flag
// - debugger reset spares the debugger itself
// - in sleep: supply, pin, debug pin reset
// - sleep stops crystal, clock, cpu; peripherals idle
// - recovery: 514 osc edges then 16 clocks
// - recovery leaves register file untouched
// - any recovery sets sleep wake flag
// - watchdog in sleep: recovery, both flags
// - watchdog interrupt served after recovery ends
// - enabled wake pin edge starts recovery
// - pin capture off in sleep and recovery
// - short reset: 66 osc edges then 16
`timescale 1ns/1ns
`include "rsc_defs.svh"

module rsc_reset_ctrl
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic wdt_osc,
  input wire logic por_ok,
  input wire logic bod_low,
  input wire logic ext_rst_n,
  input wire logic debug_pin_n,
  input wire logic wdt_timeout,
  input wire logic [`RSC_GPIO_W-1:0] gpio_in,
  input wire logic sleep_req,
  input wire rsc_pkg::rsc_axi_req_t axi_req,
  output rsc_pkg::rsc_axi_rsp_t axi_rsp,
  output rsc_pkg::rsc_ctl_t ctl
);

  rsc_pkg::rsc_regs_t q; // registered state
  rsc_pkg::rsc_regs_t d; // next state
  logic [`RSC_SYN_W-1:0] syn; // synchronised inputs
  logic osc_edge; // rising edge of watchdog oscillator
  logic wdt_edge; // watchdog time-out event
  logic [`RSC_GPIO_W-1:0] wake_edge; // enabled wake pin changes
  logic supply_bad; // power-on or brownout fault
  logic osc_last; // last oscillator edge of the phase
  logic wr_fire; // write address and data both held
  logic [31:0] rd_word; // read mux result
  logic rd_hit; // read address mapped

  // *************************************************************
  // input synchronisers
  // *************************************************************
  rsc_sync2 u_sync
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .din({gpio_in, wdt_timeout, debug_pin_n, ext_rst_n, bod_low, por_ok,
          wdt_osc}),
    .dout(syn)
  );

  // event detection on synchronised inputs
  always_comb
  begin
    osc_edge = syn[`RSC_SYN_OSC] & ~q.osc_prev;
    wdt_edge = syn[`RSC_SYN_WDT] & ~q.wdt_prev;
    // either direction counts on an enabled pin
    wake_edge = (syn[`RSC_SYN_GPIO +: `RSC_GPIO_W] ^ q.gpio_prev) & q.wake_en;
    // brownout is ignored while its detector is off in sleep
    supply_bad = ~syn[`RSC_SYN_POR] |
                 (syn[`RSC_SYN_BOD] & (q.st != rsc_pkg::ST_SLEEP));
    // long count for system and recovery
    if (q.kind == rsc_pkg::K_SHORT)
    begin
      osc_last = (q.osc_cnt == `RSC_OSC_SHORT - 10'h001);
    end
    else
    begin
      osc_last = (q.osc_cnt == `RSC_OSC_LONG - 10'h001);
    end
  end

  // *************************************************************
  // register read mux
  // *************************************************************
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (axi_req.araddr == `RSC_OFS_WDCTL)
    begin
      rd_word[`RSC_FLAG_W-1:0] = q.flags;
    end
    else if (axi_req.araddr == `RSC_OFS_DBGCTL)
    begin
      rd_word[`RSC_DBG_RST_BIT] = q.dbg_req;
    end
    else if (axi_req.araddr == `RSC_OFS_OPTION)
    begin
      rd_word[1:0] = q.option;
    end
    else if (axi_req.araddr == `RSC_OFS_WAKE_EN)
    begin
      rd_word[`RSC_GPIO_W-1:0] = q.wake_en;
    end
    else if (axi_req.araddr == `RSC_OFS_STATUS)
    begin
      rd_word[2:0] = q.st;
    end
    else
    begin
      // unmapped: zero data, slave error
      rd_hit = 1'b0;
    end
  end

  // *************************************************************
  // next-state logic
  // *************************************************************
  always_comb
  begin
    d = q;
    d.osc_prev = syn[`RSC_SYN_OSC];
    d.wdt_prev = syn[`RSC_SYN_WDT];
    d.gpio_prev = syn[`RSC_SYN_GPIO +: `RSC_GPIO_W];
    d.ctl.vec_fetch = 1'b0;
    d.ctl.wdt_irq = 1'b0;
    wr_fire = q.aw_got & q.w_got & ~q.rsp.bvalid;

    // write address and data, taken in either order
    if (axi_req.awvalid && q.rsp.awready)
    begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready)
    begin
      d.w_got = 1'b1;
      d.wbyte = axi_req.wdata[7:0];
      d.wlane0 = axi_req.wstrb[0];
    end
    if (wr_fire)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = `RSC_RESP_OKAY;
      if (q.awaddr == `RSC_OFS_WDCTL)
      begin
        // write one to clear; a hardware set below wins
        if (q.wlane0)
        begin
          d.flags = q.flags & ~q.wbyte[`RSC_FLAG_W-1:0];
        end
      end
      else if (q.awaddr == `RSC_OFS_DBGCTL)
      begin
        if (q.wlane0)
        begin
          d.dbg_req = q.wbyte[`RSC_DBG_RST_BIT];
        end
      end
      else if (q.awaddr == `RSC_OFS_OPTION)
      begin
        if (q.wlane0)
        begin
          d.option = q.wbyte[1:0];
        end
      end
      else if (q.awaddr == `RSC_OFS_WAKE_EN)
      begin
        if (q.wlane0)
        begin
          d.wake_en = q.wbyte;
        end
      end
      else if (q.awaddr != `RSC_OFS_STATUS)
      begin
        d.rsp.bresp = `RSC_RESP_SLVERR;
      end
    end
    // response held until bready
    if (q.rsp.bvalid && axi_req.bready)
    begin
      d.rsp.bvalid = 1'b0;
    end
    d.rsp.awready = ~d.aw_got & ~d.rsp.bvalid;
    d.rsp.wready = ~d.w_got & ~d.rsp.bvalid;

    // read: address taken, data one cycle later
    d.rsp.arready = 1'b0;
    if (axi_req.arvalid && q.rsp.arready)
    begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = rd_word;
      d.rsp.rresp = rd_hit ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
    end
    else if (q.rsp.rvalid && axi_req.rready)
    begin
      d.rsp.rvalid = 1'b0;
    end
    d.rsp.arready = ~d.rsp.rvalid & ~(axi_req.arvalid & q.rsp.arready);

    // reset sequencer
    if (supply_bad)
    begin
      // supply fault beats every source, any mode
      d.st = rsc_pkg::ST_HOLD;
      d.kind = rsc_pkg::K_SYSTEM;
      d.pend = '0;
      d.pend[`RSC_FLAG_POR] = 1'b1;
      d.irq_pend = 1'b0;
      d.keep_ocd = 1'b0;
    end
    else
    begin
      case (q.st)
        rsc_pkg::ST_HOLD:
        begin
          // supply good: start the oscillator count
          d.st = rsc_pkg::ST_OSC;
          d.osc_cnt = '0;
        end
        rsc_pkg::ST_OSC:
        begin
          // count oscillator edges, then the system clock phase
          if (osc_edge)
          begin
            d.osc_cnt = q.osc_cnt + 10'h001;
            if (osc_last)
            begin
              d.st = rsc_pkg::ST_SYSCLK;
              d.sys_cnt = '0;
            end
          end
        end
        rsc_pkg::ST_SYSCLK:
        begin
          if (q.sys_cnt != `RSC_SYS_LAST)
          begin
            d.sys_cnt = q.sys_cnt + 5'h01;
          end
          else if (syn[`RSC_SYN_EXT])
          begin
            // exit only once the reset pin is high
            d.st = rsc_pkg::ST_RUN;
            d.flags = q.pend;
            // cpu loads pc from the reset vector
            d.ctl.vec_fetch = 1'b1;
            d.ctl.wdt_irq = q.irq_pend;
            d.irq_pend = 1'b0;
            d.keep_ocd = 1'b0;
          end
        end
        rsc_pkg::ST_RUN:
        begin
          d.osc_cnt = '0;
          d.pend = '0;
          if (q.dbg_req)
          begin
            d.st = rsc_pkg::ST_OSC;
            d.kind = rsc_pkg::K_SYSTEM;
            d.keep_ocd = 1'b1;
            d.dbg_req = 1'b0;
          end
          else if (!syn[`RSC_SYN_EXT])
          begin
            d.st = rsc_pkg::ST_OSC;
            d.kind = rsc_pkg::K_SHORT;
            d.pend[`RSC_FLAG_EXT] = 1'b1;
          end
          else if (wdt_edge && q.option[`RSC_OPT_WDT_RST])
          begin
            d.st = rsc_pkg::ST_OSC;
            d.kind = rsc_pkg::K_SHORT;
            d.pend[`RSC_FLAG_WDT] = 1'b1;
          end
          else if (sleep_req)
          begin
            d.st = rsc_pkg::ST_SLEEP;
          end
        end
        rsc_pkg::ST_SLEEP:
        begin
          d.osc_cnt = '0;
          d.pend = '0;
          if (!syn[`RSC_SYN_EXT] || !syn[`RSC_SYN_DBG])
          begin
            // pin or debug pin in sleep: system reset
            d.st = rsc_pkg::ST_OSC;
            d.kind = rsc_pkg::K_SYSTEM;
            d.pend[`RSC_FLAG_EXT] = ~syn[`RSC_SYN_EXT];
          end
          else if (wdt_edge)
          begin
            d.st = rsc_pkg::ST_OSC;
            d.kind = rsc_pkg::K_RECOV;
            d.pend[`RSC_FLAG_WDT] = 1'b1;
            d.pend[`RSC_FLAG_SLEEP] = 1'b1;
            d.irq_pend = ~q.option[`RSC_OPT_WDT_RST] &
                         q.option[`RSC_OPT_IRQ_EN];
          end
          else if (|wake_edge)
          begin
            d.st = rsc_pkg::ST_OSC;
            d.kind = rsc_pkg::K_RECOV;
            d.pend[`RSC_FLAG_SLEEP] = 1'b1;
          end
        end
        default:
        begin
          d.st = rsc_pkg::ST_HOLD;
        end
      endcase
    end

    // control outputs follow the next state
    d.ctl.core_rst = (d.st == rsc_pkg::ST_HOLD) ||
                     (d.st == rsc_pkg::ST_OSC) ||
                     (d.st == rsc_pkg::ST_SYSCLK);
    // recovery leaves control registers and file alone
    d.ctl.ctrl_rst = d.ctl.core_rst && (d.kind != rsc_pkg::K_RECOV);
    // debugger reset only when not requested by it
    d.ctl.ocd_rst = d.ctl.ctrl_rst && !d.keep_ocd;
    // crystal, clock and peripherals stop in sleep
    d.ctl.xtal_en = (d.st != rsc_pkg::ST_SLEEP);
    d.ctl.sysclk_en = (d.st == rsc_pkg::ST_SYSCLK) ||
                      (d.st == rsc_pkg::ST_RUN);
    d.ctl.periph_idle = (d.st != rsc_pkg::ST_RUN);
    d.ctl.bod_en = (d.st != rsc_pkg::ST_SLEEP);
    // input capture resumes only after the delay
    d.ctl.pin_capture_en = (d.st == rsc_pkg::ST_RUN);
    d.ctl.vec_addr = `RSC_VEC_ADDR;
  end

  // *************************************************************
  // state register
  // *************************************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.st <= rsc_pkg::ST_HOLD;
      q.kind <= rsc_pkg::K_SYSTEM;
      q.option <= `RSC_OPT_RST;
      q.ctl.core_rst <= 1'b1;
      q.ctl.ctrl_rst <= 1'b1;
      q.ctl.ocd_rst <= 1'b1;
      q.ctl.xtal_en <= 1'b1;
      q.ctl.periph_idle <= 1'b1;
      q.ctl.bod_en <= 1'b1;
      q.ctl.vec_addr <= `RSC_VEC_ADDR;
      q.pend <= `RSC_FLAG_W'(1) << `RSC_FLAG_POR;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign axi_rsp = q.rsp;
  assign ctl = q.ctl;

  // *************************************************************
  // assertions
  // *************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n || !ce);

  // the sixteen-clock phase: clock on, reset held
  sequence s_sys_phase;
    (q.ctl.sysclk_en && q.ctl.core_rst) [*8] ##1
    (q.ctl.sysclk_en && q.ctl.core_rst) [*8];
  endsequence

  sequence s_osc_done;
    q.st == rsc_pkg::ST_OSC && osc_edge && osc_last;
  endsequence

  a_supply_wins: assert property (
    supply_bad |=> q.st == rsc_pkg::ST_HOLD && q.ctl.ocd_rst)
    else $error("supply fault did not force hold");

  a_sys_phase_len: assert property (
    s_osc_done |=> s_sys_phase)
    else $error("system clock phase shorter than sixteen");

  a_short_count: assert property (
    (s_osc_done ##0 q.kind == rsc_pkg::K_SHORT) |=>
      q.osc_cnt == `RSC_OSC_SHORT && q.st == rsc_pkg::ST_SYSCLK)
    else $error("short reset oscillator count wrong");

  a_por_flag: assert property (
    (q.st == rsc_pkg::ST_SYSCLK && q.pend[`RSC_FLAG_POR]) ##1
      (q.st == rsc_pkg::ST_RUN) |-> q.flags[`RSC_FLAG_POR])
    else $error("power flag missing after power-on");

  a_sleep_bod_off: assert property (
    q.st == rsc_pkg::ST_SLEEP |-> !q.ctl.bod_en && !q.ctl.xtal_en
      && !q.ctl.sysclk_en)
    else $error("detector or clock left on in sleep");

  a_wdt_opt_off: assert property (
    (q.st == rsc_pkg::ST_RUN && wdt_edge && !q.option[`RSC_OPT_WDT_RST]
     && !supply_bad && syn[`RSC_SYN_EXT] && !q.dbg_req)
      |=> !q.ctl.core_rst)
    else $error("watchdog reset while not selected");

  a_pin_holds: assert property (
    (q.st == rsc_pkg::ST_SYSCLK && !syn[`RSC_SYN_EXT]) |=> q.ctl.core_rst)
    else $error("reset released while pin low");

  a_exit_vector: assert property (
    $fell(q.ctl.core_rst) |-> q.ctl.vec_fetch &&
      q.ctl.vec_addr == `RSC_VEC_ADDR)
    else $error("no vector fetch on reset exit");

  a_capture_off: assert property (
    (q.st == rsc_pkg::ST_SLEEP && |wake_edge && !supply_bad) |=>
      !q.ctl.pin_capture_en [*2])
    else $error("pin capture enabled during recovery");

  a_recov_keep: assert property (
    (q.kind == rsc_pkg::K_RECOV && q.ctl.core_rst) |-> !q.ctl.ctrl_rst)
    else $error("recovery reset control registers");

  a_flags_keep: assert property (
    (!wr_fire && q.st != rsc_pkg::ST_SYSCLK) |=>
      (q.flags & $past(q.flags)) == $past(q.flags))
    else $error("cause flag lost without clear");

endmodule

// ### verilog/rsc_sync2.sv
/*
 * two-flop synchroniser for the controller's asynchronous inputs.
 * assumes inputs from pins or other clocks; only the second stage is read.
 */
`timescale 1ns/1ns
`include "rsc_defs.svh"

module rsc_sync2
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [`RSC_SYN_W-1:0] din,
  output logic [`RSC_SYN_W-1:0] dout
);

  rsc_pkg::rsc_sync_t sync_q; // both stages
  rsc_pkg::rsc_sync_t sync_d; // next value

  // *************************************************************
  // stage shift
  // *************************************************************
  always_comb
  begin
    sync_d = sync_q;
    sync_d.s1 = din;
    sync_d.s2 = sync_q.s1;
  end

  // registered, frozen while ce is low
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_q <= {`RSC_SYN_RST, `RSC_SYN_RST};
    end
    else if (ce)
    begin
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q.s2;

endmodule
